// >>> inc/cpu_pkg.sv
// Shared constants, field layouts and carrier types of the 8-bit core
package cpu_pkg;

    // ************************************************************
    // Instruction word layout
    // ************************************************************
    localparam int INSTR_W = 18;
    localparam int OPC_HI = 17;
    localparam int OPC_LO = 12;
    localparam int X_HI = 11;
    localparam int X_LO = 8;
    localparam int Y_HI = 7;
    localparam int Y_LO = 4;
    localparam int K_HI = 7;
    localparam int K_LO = 0;
    localparam int IMM_HI = 11;
    localparam int IMM_LO = 4;
    localparam int P_HI = 3;
    localparam int P_LO = 0;
    localparam int PC_W = 12;
    localparam int NREGS = 16;

    // ************************************************************
    // Opcodes (encoding is arbitrary)
    // ************************************************************
    localparam logic [5:0] OP_LOAD_K = 6'h01;
    localparam logic [5:0] OP_FETCH_PTR = 6'h0A;
    localparam logic [5:0] OP_FETCH_SS = 6'h0B;
    localparam logic [5:0] OP_EN_INT = 6'h28;
    localparam logic [5:0] OP_DIS_INT = 6'h29;
    localparam logic [5:0] OP_CONST_OUT = 6'h2B;
    localparam logic [5:0] OP_OUTPUT_PTR = 6'h2C;
    localparam logic [5:0] OP_OUTPUT_IMM = 6'h2D;
    localparam logic [5:0] OP_STORE_PTR = 6'h2E;
    localparam logic [5:0] OP_STORE_SS = 6'h2F;

    // ************************************************************
    // Register map and reset values
    // ************************************************************
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam int CTRL_HOLD_BIT = 0;
    localparam int ST_IRQ_EN_BIT = 0;
    localparam int ST_ZERO_BIT = 1;
    localparam int ST_CARRY_BIT = 2;
    localparam int ST_PC_LO = 8;
    localparam logic CTRL_HOLD_RST = 1'b0;
    localparam logic [PC_W-1:0] PC_RST = 12'h000;
    localparam int SCRATCH_DEFAULT = 64;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic {PH_FETCH, PH_EXEC} phase_t;

    typedef struct packed {
        logic [7:0] port_address_bus;
        logic [7:0] out_data;
        logic write_strobe;
        logic k_write_strobe;
    } port_bus_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

endpackage

// >>> hdl/scratch_memory.sv
// Scratch memory with registered read data
`timescale 1ns/10ps
module scratch_memory #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // Clock
    input wire logic clock,
    // Write side
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // Read side
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata_q
);
    logic [7:0] mem [DEPTH];

    // Contents are undefined after reset, as in a block memory
    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end
endmodule

// >>> hdl/apb_regs.sv
// APB slave holding the control word and showing core status
`timescale 1ns/10ps
module apb_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Bus
    input wire cpu_pkg::apb_req_t req,
    output cpu_pkg::apb_rsp_t rsp,
    // Core side
    input wire logic [31:0] status,
    output logic hold_q
);
    typedef struct packed {
        cpu_pkg::apb_rsp_t rsp;
        logic hold;
    } st_t;

    st_t q;
    st_t d;
    logic setup;
    logic mapped;

    always_comb begin
        d = q;
        setup = req.psel && !req.penable;
        mapped = (req.paddr == cpu_pkg::CTRL_OFS) ||
                 (req.paddr == cpu_pkg::STATUS_OFS);
        // No wait states: ready in the first access cycle
        d.rsp.pready = setup;
        d.rsp.pslverr = setup && !mapped;
        if (setup) begin
            d.rsp.prdata = 32'h0000_0000;
            if (req.paddr == cpu_pkg::CTRL_OFS) begin
                d.rsp.prdata[cpu_pkg::CTRL_HOLD_BIT] = q.hold;
            end else if (req.paddr == cpu_pkg::STATUS_OFS) begin
                d.rsp.prdata = status;
            end
        end
        if (req.psel && req.penable && q.rsp.pready && req.pwrite &&
            req.paddr == cpu_pkg::CTRL_OFS) begin
            d.hold = req.pwdata[cpu_pkg::CTRL_HOLD_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '{rsp: '0, hold: cpu_pkg::CTRL_HOLD_RST};
        end else begin
            q <= d;
        end
    end

    assign rsp = q.rsp;
    assign hold_q = q.hold;
endmodule

// >>> hdl/core_exec.sv
// Two-cycle core: constant and variable output, scratch store and fetch,
// interrupt enable control
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/10ps
module core_exec #(
    parameter int SCRATCH_SIZE = cpu_pkg::SCRATCH_DEFAULT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register bus
    input wire cpu_pkg::apb_req_t apb_req,
    output cpu_pkg::apb_rsp_t apb_rsp,
    // Program memory
    output logic [cpu_pkg::PC_W-1:0] prog_addr,
    input wire logic [cpu_pkg::INSTR_W-1:0] instr,
    // Output ports
    output cpu_pkg::port_bus_t port,
    // Handshake and interrupt
    input wire logic sleep,
    input wire logic interrupt,
    output logic interrupt_seen
);
    localparam int AW = $clog2(SCRATCH_SIZE);

    // ************************************************************
    // Build checks
    // ************************************************************
    if (SCRATCH_SIZE != 64 && SCRATCH_SIZE != 128 &&
        SCRATCH_SIZE != 256) begin : g_bad
        $error("scratch size must be 64, 128 or 256");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        cpu_pkg::phase_t phase;
        logic [cpu_pkg::PC_W-1:0] pc;
        logic [cpu_pkg::INSTR_W-1:0] ir;
        logic [cpu_pkg::NREGS-1:0][7:0] regs;
        logic zero;
        logic carry;
        logic irq_en;
        logic int_seen;
        cpu_pkg::port_bus_t port;
    } st_t;

    st_t q;
    st_t d;

    logic hold_q;
    logic stall;
    logic take;
    logic [5:0] opc;
    logic [7:0] xval;
    logic [7:0] yval;
    logic scr_we;
    logic [AW-1:0] scr_waddr;
    logic [AW-1:0] scr_raddr;
    logic [7:0] scr_rdata_q;
    logic [31:0] status;

    function automatic logic [5:0] opcode_of(
        input logic [cpu_pkg::INSTR_W-1:0] w
    );
        opcode_of = w[cpu_pkg::OPC_HI:cpu_pkg::OPC_LO];
    endfunction

    // Only the low bits that the configured size needs are kept
    function automatic logic [AW-1:0] scr_addr(
        input logic [cpu_pkg::INSTR_W-1:0] w,
        input logic [7:0] ptr,
        input logic by_ptr
    );
        logic [7:0] full;
        full = by_ptr ? ptr : w[cpu_pkg::K_HI:cpu_pkg::K_LO];
        scr_addr = full[AW-1:0];
    endfunction

    // ************************************************************
    // Submodules
    // ************************************************************
    apb_regs u_regs (
        .clock(clock),
        .sys_rst(sys_rst),
        .req(apb_req),
        .rsp(apb_rsp),
        .status(status),
        .hold_q(hold_q)
    );

    scratch_memory #(
        .DEPTH(SCRATCH_SIZE),
        .AW(AW)
    ) u_scratch (
        .clock(clock),
        .we(scr_we),
        .waddr(scr_waddr),
        .wdata(xval),
        .raddr(scr_raddr),
        .rdata_q(scr_rdata_q)
    );

    // ************************************************************
    // Execution
    // ************************************************************
    always_comb begin
        status = 32'h0000_0000;
        status[cpu_pkg::ST_IRQ_EN_BIT] = q.irq_en;
        status[cpu_pkg::ST_ZERO_BIT] = q.zero;
        status[cpu_pkg::ST_CARRY_BIT] = q.carry;
        status[cpu_pkg::ST_PC_LO +: cpu_pkg::PC_W] = q.pc;
    end

    always_comb begin
        d = q;
        // Sleep and software hold both freeze the fetch phase
        stall = sleep || hold_q;
        take = (q.phase == cpu_pkg::PH_FETCH) && !stall;
        opc = opcode_of(instr);
        xval = q.regs[instr[cpu_pkg::X_HI:cpu_pkg::X_LO]];
        yval = q.regs[instr[cpu_pkg::Y_HI:cpu_pkg::Y_LO]];
        scr_we = take && (opc == cpu_pkg::OP_STORE_SS ||
                          opc == cpu_pkg::OP_STORE_PTR);
        scr_waddr = scr_addr(instr, yval,
                             opc == cpu_pkg::OP_STORE_PTR);
        scr_raddr = scr_addr(instr, yval,
                             opc == cpu_pkg::OP_FETCH_PTR);
        d.port.write_strobe = 1'b0;
        d.port.k_write_strobe = 1'b0;
        d.int_seen = interrupt && q.irq_en;
        case (q.phase)
            cpu_pkg::PH_FETCH: begin
                if (take) begin
                    d.ir = instr;
                    d.pc = q.pc + 1'b1;
                    d.phase = cpu_pkg::PH_EXEC;
                    case (opc)
                        cpu_pkg::OP_LOAD_K: begin
                            d.regs[instr[cpu_pkg::X_HI:cpu_pkg::X_LO]] =
                                instr[cpu_pkg::K_HI:cpu_pkg::K_LO];
                        end
                        cpu_pkg::OP_CONST_OUT: begin
                            // Upper address bits are driven low
                            d.port.out_data =
                                instr[cpu_pkg::IMM_HI:cpu_pkg::IMM_LO];
                            d.port.port_address_bus =
                                {4'h0, instr[cpu_pkg::P_HI:cpu_pkg::P_LO]};
                            d.port.k_write_strobe = 1'b1;
                        end
                        cpu_pkg::OP_OUTPUT_IMM, cpu_pkg::OP_OUTPUT_PTR: begin
                            d.port.out_data = xval;
                            d.port.port_address_bus =
                                (opc == cpu_pkg::OP_OUTPUT_PTR) ? yval :
                                instr[cpu_pkg::K_HI:cpu_pkg::K_LO];
                            d.port.write_strobe = 1'b1;
                        end
                        cpu_pkg::OP_EN_INT: begin
                            d.irq_en = 1'b1;
                        end
                        cpu_pkg::OP_DIS_INT: begin
                            d.irq_en = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            cpu_pkg::PH_EXEC: begin
                d.phase = cpu_pkg::PH_FETCH;
                if (opcode_of(q.ir) == cpu_pkg::OP_FETCH_SS ||
                    opcode_of(q.ir) == cpu_pkg::OP_FETCH_PTR) begin
                    d.regs[q.ir[cpu_pkg::X_HI:cpu_pkg::X_LO]] =
                        scr_rdata_q;
                end
            end
            default: begin
                d.phase = cpu_pkg::PH_FETCH;
            end
        endcase
    end

    // Reset lands in the execute phase so the program memory can
    // register word zero before the first fetch
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '{phase: cpu_pkg::PH_EXEC, pc: cpu_pkg::PC_RST,
                   ir: '0, regs: '0, zero: 1'b0, carry: 1'b0,
                   irq_en: 1'b0, int_seen: 1'b0, port: '0};
        end else begin
            q <= d;
        end
    end

    assign prog_addr = q.pc;
    assign port = q.port;
    assign interrupt_seen = q.int_seen;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_K_DATA: assert property (@(posedge clock) disable iff (sys_rst)
        take && opc == cpu_pkg::OP_CONST_OUT |=>
        port.k_write_strobe && !port.write_strobe &&
        port.out_data == $past(instr[11:4]))
        else $error("constant data not driven");

    AST_K_ADDR: assert property (@(posedge clock) disable iff (sys_rst)
        take && opc == cpu_pkg::OP_CONST_OUT |=>
        port.port_address_bus[3:0] == $past(instr[3:0]))
        else $error("constant port address wrong");

    AST_K_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
        take && opc == cpu_pkg::OP_CONST_OUT |=> ##1
        q.regs == $past(q.regs, 2) && q.zero == $past(q.zero, 2) &&
        q.carry == $past(q.carry, 2))
        else $error("constant output disturbed state");

    AST_TWO_CLK: assert property (@(posedge clock) disable iff (sys_rst)
        take |=> q.phase == cpu_pkg::PH_EXEC && !take ##1
        q.phase == cpu_pkg::PH_FETCH)
        else $error("instruction not two cycles");

    AST_STORE_KEEP: assert property (@(posedge clock)
        disable iff (sys_rst)
        scr_we |=> q.regs == $past(q.regs) && q.zero == $past(q.zero))
        else $error("store changed registers");

    AST_FETCH_LOAD: assert property (@(posedge clock)
        disable iff (sys_rst)
        take && (opc == cpu_pkg::OP_FETCH_SS ||
                 opc == cpu_pkg::OP_FETCH_PTR) |=> ##1
        q.regs[q.ir[11:8]] == $past(scr_rdata_q))
        else $error("fetch did not load register");

    AST_RESET_STATE: assert property (@(posedge clock)
        $past(sys_rst) && !sys_rst |->
        !q.irq_en && q.pc == 12'h000 && !interrupt_seen)
        else $error("reset state wrong");

    AST_IE_SET: assert property (@(posedge clock) disable iff (sys_rst)
        take && opc == cpu_pkg::OP_EN_INT |=> q.irq_en && !port.write_strobe)
        else $error("enable did not set flag");

    AST_IE_CLR: assert property (@(posedge clock) disable iff (sys_rst)
        take && opc == cpu_pkg::OP_DIS_INT |=> !q.irq_en ##1 !interrupt_seen)
        else $error("disable did not clear flag");

    AST_VAR_STB: assert property (@(posedge clock) disable iff (sys_rst)
        port.write_strobe |-> !port.k_write_strobe ##1 !port.write_strobe)
        else $error("variable strobe too long");

    AST_K_STB: assert property (@(posedge clock) disable iff (sys_rst)
        port.k_write_strobe |->
        $past(opcode_of(instr)) == cpu_pkg::OP_CONST_OUT ##1
        !port.k_write_strobe)
        else $error("constant strobe misplaced");
endmodule

// >>> dv/port_sink_model.sv
// Far-side port decode model: split ports, hybrid port and sleep
`timescale 1ns/10ps
module port_sink_model (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Processor output bus
    input wire cpu_pkg::port_bus_t port,
    // Handshake
    input wire logic stall_en,
    output logic sleep
);
    logic [7:0] var2_q;
    logic [7:0] const2_q;
    logic [7:0] hybrid_q;
    logic [16:0] log_q[$];
    int stamp_q[$];
    int cyc;
    int fill;
    int sleep_cycles;
    logic [7:0] adr;
    assign adr = port.port_address_bus;
    // ************************************************************
    // Capture and drain
    // ************************************************************
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (sys_rst) begin
            log_q.delete();
            stamp_q.delete();
            fill = 0;
            sleep_cycles = 0;
            sleep <= 1'b0;
            // Cleared so a second run cannot pass on stale captures
            var2_q <= 8'h00;
            const2_q <= 8'h00;
            hybrid_q <= 8'h00;
        end else begin
            if (port.k_write_strobe || port.write_strobe) begin
                log_q.push_back({port.k_write_strobe, adr, port.out_data});
                stamp_q.push_back(cyc);
            end
            // Constant decode sees only the low nibble
            if (port.k_write_strobe && adr[3:0] == 4'h2) begin
                const2_q <= port.out_data;
            end
            if (port.write_strobe && adr == 8'h02) begin
                var2_q <= port.out_data;
            end
            if ((port.k_write_strobe && adr[3:0] == 4'h8) ||
                    (port.write_strobe && adr == 8'h08)) begin
                hybrid_q <= port.out_data;
                fill = fill + 1;
            end else if (fill > 0 && cyc % 8 == 0) begin
                fill = fill - 1;
            end
            // Small threshold so the stall really happens
            sleep <= stall_en && fill >= 2;
            if (sleep) begin
                sleep_cycles = sleep_cycles + 1;
            end
        end
    end
endmodule

// >>> dv/const_port_scratchpad_irq_enable_tb.sv
// Self-checking bench for constant output, scratch memory and enable flag
`timescale 1ns/10ps
module const_port_scratchpad_irq_enable_tb;
    logic clock;
    logic sys_rst;
    cpu_pkg::apb_req_t apb_req;
    cpu_pkg::apb_rsp_t apb_rsp;
    logic [11:0] prog_addr;
    logic [17:0] instr;
    cpu_pkg::port_bus_t port;
    logic sleep;
    logic interrupt;
    logic interrupt_seen;
    logic stall_en;
    logic [17:0] prog [32];
    int fail_count;
    int tests_run;
    int seen_cycles;
    logic [31:0] rd;
    logic [31:0] pc0;
    logic err;
    // Expected writes: {constant strobe, address, data}
    logic [16:0] exp_log [11] = '{17'h108A5, 17'h10200, 17'h102FF,
        17'h0023C, 17'h0083C, 17'h02A3C, 17'h00877, 17'h10811,
        17'h0013C, 17'h10805, 17'h0013C};

    core_exec #(.SCRATCH_SIZE(64)) DUT (.clock(clock), .sys_rst(sys_rst),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .prog_addr(prog_addr),
        .instr(instr), .port(port), .sleep(sleep),
        .interrupt(interrupt), .interrupt_seen(interrupt_seen));
    port_sink_model sink (.clock(clock), .sys_rst(sys_rst), .port(port),
        .stall_en(stall_en), .sleep(sleep));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Past the program end only no-ops, so nothing re-runs
    always @(posedge clock) begin
        instr <= (prog_addr < 12'h020) ? prog[prog_addr[4:0]] : 18'h00000;
        if (sys_rst) begin
            seen_cycles <= 0;
        end else if (interrupt_seen === 1'b1) begin
            seen_cycles <= seen_cycles + 1;
        end
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
            input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clock);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
            pwdata: d};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        chk(n < 20, 1, "bus answer");
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        apb_req = '0;
        sys_rst = 1'b1;
        interrupt = 1'b1;
        stall_en = 1'b0;
        fail_count = 0;
        tests_run = 0;
        foreach (prog[i]) prog[i] = '0;
        prog[0] = {cpu_pkg::OP_CONST_OUT, 8'hA5, 4'h8};
        prog[1] = {cpu_pkg::OP_CONST_OUT, 8'h00, 4'h2};
        prog[2] = {cpu_pkg::OP_CONST_OUT, 8'hFF, 4'h2};
        prog[3] = {cpu_pkg::OP_LOAD_K, 4'h1, 8'h3C};
        prog[4] = {cpu_pkg::OP_OUTPUT_IMM, 4'h1, 8'h02};
        prog[5] = {cpu_pkg::OP_OUTPUT_IMM, 4'h1, 8'h08};
        prog[6] = {cpu_pkg::OP_STORE_SS, 4'h1, 8'h6A};
        prog[7] = {cpu_pkg::OP_LOAD_K, 4'h2, 8'h2A};
        prog[8] = {cpu_pkg::OP_FETCH_PTR, 4'h3, 8'h20};
        prog[9] = {cpu_pkg::OP_LOAD_K, 4'h4, 8'hEA};
        prog[10] = {cpu_pkg::OP_LOAD_K, 4'h5, 8'h77};
        prog[11] = {cpu_pkg::OP_STORE_PTR, 4'h5, 8'h40};
        prog[12] = {cpu_pkg::OP_FETCH_SS, 4'h6, 8'h6A};
        prog[13] = {cpu_pkg::OP_OUTPUT_PTR, 4'h3, 8'h20};
        prog[14] = {cpu_pkg::OP_OUTPUT_IMM, 4'h6, 8'h08};
        prog[15] = {cpu_pkg::OP_CONST_OUT, 8'h11, 4'h8};
        prog[16] = {cpu_pkg::OP_OUTPUT_IMM, 4'h1, 8'h01};
        prog[17] = {cpu_pkg::OP_EN_INT, 4'h0, 8'h00};
        prog[18] = {cpu_pkg::OP_CONST_OUT, 8'h05, 4'h8};
        prog[19] = {cpu_pkg::OP_DIS_INT, 4'h0, 8'h00};
        prog[20] = {cpu_pkg::OP_OUTPUT_IMM, 4'h1, 8'h01};
        // Phase 1 repeats the program with the far side stalling
        for (int ph = 0; ph < 2; ph++) begin
            sys_rst <= 1'b1;
            stall_en <= (ph == 1);
            repeat (12) @(posedge clock);
            sys_rst <= 1'b0;
            @(posedge clock);
            chk(prog_addr, 0, "start address");
            repeat (ph ? 200 : 60) @(posedge clock);
            chk(sink.log_q.size(), 11, "write count");
            for (int i = 0; i < 11; i++) begin
                chk(sink.log_q[i] & (exp_log[i][16] ? 17'h10FFF : 17'h1FFFF),
                    exp_log[i], "write");
            end
            chk(sink.var2_q, 8'h3C, "variable port");
            chk(sink.const2_q, 8'hFF, "constant port");
            chk(sink.hybrid_q, 8'h05, "hybrid port");
            if (ph == 0) begin
                chk(sink.stamp_q[1] - sink.stamp_q[0], 2, "gap");
                chk(sink.stamp_q[2] - sink.stamp_q[1], 2, "gap");
                chk(seen_cycles, 4, "enabled span");
            end else begin
                chk(sink.sleep_cycles > 0, 1, "stall seen");
            end
            $display("test phase %0d done", ph);
        end
        apb(1'b1, cpu_pkg::CTRL_OFS, 32'h00000001, rd, err);
        apb(1'b0, cpu_pkg::STATUS_OFS, 32'h0, pc0, err);
        repeat (10) @(posedge clock);
        apb(1'b0, cpu_pkg::STATUS_OFS, 32'h0, rd, err);
        chk(rd, pc0, "held status");
        chk(rd[2:0], 3'h0, "flags");
        apb(1'b1, cpu_pkg::STATUS_OFS, 32'hFFFFFFFF, rd, err);
        apb(1'b0, cpu_pkg::STATUS_OFS, 32'h0, rd, err);
        chk(rd, pc0, "status read only");
        apb(1'b0, 12'h008, 32'h0, rd, err);
        chk(err, 1, "unmapped error");
        chk(rd, 0, "unmapped data");
        apb(1'b1, cpu_pkg::CTRL_OFS, 32'h0, rd, err);
        apb(1'b0, cpu_pkg::CTRL_OFS, 32'h0, rd, err);
        chk(rd[0], 0, "hold cleared");
        $display("test register bus done");
        test_done;
    end
    initial begin
        repeat (2000) @(posedge clock);
        fail_count++;
        $display("BAD %0t timeout", $time);
        test_done;
    end
endmodule
